// [logic/dram_control_signalling.sv]
// Register access over Wishbone and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "dram_ctrl_defs.svh"

module dram_control_signalling
    import dram_pkg::*;
#(
    parameter int NUM_ROWS = 8
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [NUM_ROWS-1:0] column_strobe_copy_a_n_o,
    output logic [NUM_ROWS-1:0] column_strobe_copy_b_n_o,
    output logic [NUM_ROWS-1:0] row_strobe_copy_a_n_o,
    output logic [NUM_ROWS-1:0] row_strobe_copy_b_n_o,
    output mem_addr_t mem_address_copy_a_o,
    output mem_addr_t mem_address_copy_b_o,
    output logic write_enable_copy_0_n_o,
    output logic write_enable_copy_1_n_o,
    input wire logic [7:0] memory_side_command_bus_n_i,
    output logic [7:0] memory_side_command_bus_n_o,
    output logic memory_side_command_bus_oe_n_o,
    input wire logic [1:0] memory_error_in_n_i,
    output logic [4:0] system_side_command_out_n_o,
    output logic host_data_enable_out_n_o,
    input wire logic system_error_in_n_i,
    output logic [6:0] interface_chip_command_n_o,
    output logic [1:0] interface_chip_write_drive_n_o,
    input wire logic host_bus_init_n_i,
    output logic memory_side_reset_out_n_o,
    output logic corrected_error_flag_n_o,
    input wire logic controller_number_strap_i,
    input wire logic power_good_i,
    input wire logic receiver_gate_test_i,
    input wire logic test_clk_i,
    input wire logic test_data_i,
    input wire logic test_mode_sel_i,
    input wire logic test_reset_n_i,
    output logic test_data_o,
    output logic outputs_oe_n_o
);
    localparam int SEL_W = $clog2(NUM_ROWS);
    localparam int PIN_W = 19;

    function automatic logic [31:0] byte_merge(input logic [31:0] old, input logic [31:0] wdat,
                                               input logic [3:0] sel);
        logic [31:0] v;
        v = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                v[i*8 +: 8] = wdat[i*8 +: 8];
            end
        end
        return v;
    endfunction

    // Pin synchronisers
    logic [PIN_W-1:0] pin_raw, pin_meta_reg, pin_sync_reg;
    logic tck_prev_reg;
    assign pin_raw = {memory_side_command_bus_n_i, memory_error_in_n_i, system_error_in_n_i, host_bus_init_n_i,
                      controller_number_strap_i, power_good_i, receiver_gate_test_i, test_clk_i, test_data_i,
                      test_mode_sel_i, test_reset_n_i};

    always_ff @(posedge sys_clk_i) begin
        if (ce_i) begin
            pin_meta_reg <= pin_raw;
            pin_sync_reg <= pin_meta_reg;
            tck_prev_reg <= pin_sync_reg[3];
        end
    end

    logic [7:0] memory_side_command_bus_in;
    logic [1:0] memory_error_in_in;
    logic system_error_in_in, init_in, strap_in, pgood_in, gate_in, tck_in, tdi_in, tms_in, trst_in;
    logic board_test, rx_on;
    assign tck_in = pin_sync_reg[3];
    assign tdi_in = pin_sync_reg[2];
    assign tms_in = pin_sync_reg[1];
    assign trst_in = ~pin_sync_reg[0];
    assign gate_in = pin_sync_reg[4];
    assign pgood_in = pin_sync_reg[5];
    assign strap_in = pin_sync_reg[6];
    assign board_test = ~gate_in & ~pgood_in;
    assign rx_on = ~board_test;
    assign init_in = rx_on & ~pin_sync_reg[7];
    assign system_error_in_in = rx_on & ~pin_sync_reg[8];
    assign memory_error_in_in = rx_on ? ~pin_sync_reg[10:9] : 2'h0;
    assign memory_side_command_bus_in = rx_on ? ~pin_sync_reg[18:11] : 8'h00;

    // Register file
    logic [1:0] ctrl_reg, ctrl_next;
    logic merr_en_reg, merr_en_next, serr_en_reg, serr_en_next;
    logic [4:0] sys_cmd_reg, sys_cmd_next;
    logic [6:0] mic_cmd_reg, mic_cmd_next;
    logic [7:0] mem_cmd_reg, mem_cmd_next;
    logic mem_drive_reg, mem_drive_next;
    logic sbc_reg, sbc_next, serr_reg, serr_next, cnum_reg, cnum_next;
    logic [1:0] merr_last_reg, merr_last_next;
    count_t memory_side_reset_out_cnt_reg, memory_side_reset_out_cnt_next;
    logic ack_reg, ack_next, start_reg, start_next;
    logic [31:0] dat_reg, dat_next, acc_reg, acc_next, rd_word, wr_word;
    logic hit, seq_busy, sbc_event;

    always_comb begin
        rd_word = '0;
        if ({wb_adr_i[7:2], 2'b00} == `OFF_CTRL) begin
            rd_word[1:0] = ctrl_reg;
        end else if ({wb_adr_i[7:2], 2'b00} == `OFF_ACCESS) begin
            rd_word = acc_reg;
        end else if ({wb_adr_i[7:2], 2'b00} == `OFF_STATUS) begin
            rd_word[`STAT_BUSY] = seq_busy;
            rd_word[`STAT_SBC] = sbc_reg;
            rd_word[`STAT_SERR] = serr_reg;
            rd_word[`STAT_MERR_LSB +: 2] = merr_last_reg;
            rd_word[`STAT_CNUM] = cnum_reg;
            rd_word[`STAT_MCMD_LSB +: 8] = memory_side_command_bus_in;
        end else if ({wb_adr_i[7:2], 2'b00} == `OFF_MERR_CMD) begin
            rd_word[`ERRCMD_SBC_EN] = merr_en_reg;
        end else if ({wb_adr_i[7:2], 2'b00} == `OFF_SERR_CMD) begin
            rd_word[`ERRCMD_SBC_EN] = serr_en_reg;
        end else if ({wb_adr_i[7:2], 2'b00} == `OFF_CMD) begin
            rd_word[`CMD_SYS_LSB +: 5] = sys_cmd_reg;
            rd_word[`CMD_MIC_LSB +: 7] = mic_cmd_reg;
            rd_word[`CMD_MEM_LSB +: 8] = mem_cmd_reg;
            rd_word[`CMD_MEM_DRIVE] = mem_drive_reg;
        end else if ({wb_adr_i[7:2], 2'b00} == `OFF_CNUM) begin
            rd_word[0] = cnum_reg;
        end
    end

    assign hit = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign wr_word = byte_merge(rd_word, wb_dat_i, wb_sel_i);
    assign sbc_event = (memory_error_in_in == `MEMORY_ERROR_IN_SBC);

    always_comb begin
        ctrl_next = ctrl_reg;
        acc_next = acc_reg;
        merr_en_next = merr_en_reg;
        serr_en_next = serr_en_reg;
        sys_cmd_next = sys_cmd_reg;
        mic_cmd_next = mic_cmd_reg;
        mem_cmd_next = mem_cmd_reg;
        mem_drive_next = mem_drive_reg;
        cnum_next = cnum_reg;
        start_next = 1'b0;
        ack_next = hit;
        dat_next = hit & ~wb_we_i ? rd_word : 32'h0;
        sbc_next = sbc_reg;
        serr_next = serr_reg;
        merr_last_next = (memory_error_in_in != 2'h0) ? memory_error_in_in : merr_last_reg;
        memory_side_reset_out_cnt_next = (memory_side_reset_out_cnt_reg != '0) ? memory_side_reset_out_cnt_reg - 8'h01 : memory_side_reset_out_cnt_reg;
        if (hit & wb_we_i) begin
            if ({wb_adr_i[7:2], 2'b00} == `OFF_CTRL) begin
                ctrl_next = wr_word[1:0];
            end else if ({wb_adr_i[7:2], 2'b00} == `OFF_ACCESS) begin
                if (!seq_busy && !start_reg) begin
                    acc_next = wr_word;
                    start_next = 1'b1;
                end
            end else if ({wb_adr_i[7:2], 2'b00} == `OFF_STATUS) begin
                if (wr_word[`STAT_SBC] && wb_sel_i[0]) begin
                    sbc_next = 1'b0;
                end
                if (wr_word[`STAT_SERR] && wb_sel_i[0]) begin
                    serr_next = 1'b0;
                end
            end else if ({wb_adr_i[7:2], 2'b00} == `OFF_MERR_CMD) begin
                merr_en_next = wr_word[`ERRCMD_SBC_EN];
            end else if ({wb_adr_i[7:2], 2'b00} == `OFF_SERR_CMD) begin
                serr_en_next = wr_word[`ERRCMD_SBC_EN];
            end else if ({wb_adr_i[7:2], 2'b00} == `OFF_CMD) begin
                sys_cmd_next = wr_word[`CMD_SYS_LSB +: 5];
                mic_cmd_next = wr_word[`CMD_MIC_LSB +: 7];
                mem_cmd_next = wr_word[`CMD_MEM_LSB +: 8];
                mem_drive_next = wr_word[`CMD_MEM_DRIVE];
            end
        end
        // Hardware set beats a same-cycle software clear
        if (sbc_event && (merr_en_reg || serr_en_reg)) begin
            sbc_next = 1'b1;
        end
        if (system_error_in_in) begin
            serr_next = 1'b1;
        end
        // Host-side error state restarts; configuration stays
        if (init_in) begin
            serr_next = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ctrl_reg <= `CTRL_RESET_VAL;
            acc_reg <= '0;
            merr_en_reg <= 1'b0;
            serr_en_reg <= 1'b0;
            sys_cmd_reg <= '0;
            mic_cmd_reg <= '0;
            mem_cmd_reg <= '0;
            mem_drive_reg <= 1'b0;
            cnum_reg <= strap_in;
            start_reg <= 1'b0;
            ack_reg <= 1'b0;
            dat_reg <= '0;
            sbc_reg <= 1'b0;
            serr_reg <= 1'b0;
            merr_last_reg <= '0;
            memory_side_reset_out_cnt_reg <= count_t'(`MEMORY_SIDE_RESET_OUT_CYC);
        end else if (ce_i) begin
            ctrl_reg <= ctrl_next;
            acc_reg <= acc_next;
            merr_en_reg <= merr_en_next;
            serr_en_reg <= serr_en_next;
            sys_cmd_reg <= sys_cmd_next;
            mic_cmd_reg <= mic_cmd_next;
            mem_cmd_reg <= mem_cmd_next;
            mem_drive_reg <= mem_drive_next;
            cnum_reg <= cnum_next;
            start_reg <= start_next;
            ack_reg <= ack_next;
            dat_reg <= dat_next;
            sbc_reg <= sbc_next;
            serr_reg <= serr_next;
            merr_last_reg <= merr_last_next;
            memory_side_reset_out_cnt_reg <= memory_side_reset_out_cnt_next;
        end
    end

    // Access sequencer
    mem_addr_t seq_addr;
    logic [NUM_ROWS-1:0] seq_ras, seq_cas;
    logic seq_we, seq_drv;

    dram_strobe_seq #(.NUM_ROWS(NUM_ROWS), .SEL_W(SEL_W)) u_seq (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .start_i(start_reg),
        .row_addr_i(acc_reg[`ACC_ROW_LSB +: 13]),
        .col_addr_i(acc_reg[`ACC_COL_LSB +: 13]),
        .row_sel_i(acc_reg[`ACC_SEL_LSB +: SEL_W]),
        .write_i(acc_reg[`ACC_WR_BIT]),
        .busy_o(seq_busy),
        .addr_o(seq_addr),
        .row_strobe_o(seq_ras),
        .col_strobe_o(seq_cas),
        .write_o(seq_we),
        .drive_o(seq_drv)
    );

    // Pin output stage
    logic tdo_reg, tdo_next, oe_n_reg, memory_side_reset_out_reg, sbc_out_reg, den_reg, mcmd_oe_n_reg;
    logic [4:0] sys_out_reg;

    always_comb begin
        tdo_next = tdo_reg;
        if (!tms_in || trst_in) begin
            tdo_next = 1'b0;
        end else if (tck_in && !tck_prev_reg) begin
            tdo_next = tdi_in;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            column_strobe_copy_a_n_o <= '1;
            column_strobe_copy_b_n_o <= '1;
            row_strobe_copy_a_n_o <= '1;
            row_strobe_copy_b_n_o <= '1;
            mem_address_copy_a_o <= '0;
            mem_address_copy_b_o <= '0;
            write_enable_copy_0_n_o <= 1'b1;
            write_enable_copy_1_n_o <= 1'b1;
            interface_chip_write_drive_n_o <= 2'h3;
            interface_chip_command_n_o <= 7'h7f;
            memory_side_command_bus_n_o <= 8'hff;
            mcmd_oe_n_reg <= 1'b1;
            sys_out_reg <= 5'h1f;
            den_reg <= 1'b1;
            memory_side_reset_out_reg <= 1'b0;
            sbc_out_reg <= 1'b1;
            tdo_reg <= 1'b0;
            oe_n_reg <= 1'b0;
        end else if (ce_i) begin
            column_strobe_copy_a_n_o <= ~seq_cas;
            column_strobe_copy_b_n_o <= ~seq_cas;
            row_strobe_copy_a_n_o <= ~seq_ras;
            row_strobe_copy_b_n_o <= ~seq_ras;
            mem_address_copy_a_o <= seq_addr;
            mem_address_copy_b_o <= seq_addr;
            write_enable_copy_0_n_o <= ~seq_we;
            write_enable_copy_1_n_o <= ~seq_we;
            interface_chip_write_drive_n_o <= {2{~seq_drv}};
            interface_chip_command_n_o <= ~mic_cmd_reg;
            memory_side_command_bus_n_o <= ~mem_cmd_reg;
            mcmd_oe_n_reg <= ~mem_drive_reg | board_test;
            sys_out_reg <= init_in ? 5'h1f : ~sys_cmd_reg;
            den_reg <= ~(ctrl_reg[`CTRL_DATA_EN] & ~init_in);
            memory_side_reset_out_reg <= ~(ctrl_reg[`CTRL_MEM_RESET] | (memory_side_reset_out_cnt_reg != '0));
            sbc_out_reg <= ~sbc_reg;
            tdo_reg <= tdo_next;
            oe_n_reg <= board_test;
        end
    end

    assign memory_side_command_bus_oe_n_o = mcmd_oe_n_reg;
    assign system_side_command_out_n_o = sys_out_reg;
    assign host_data_enable_out_n_o = den_reg;
    assign memory_side_reset_out_n_o = memory_side_reset_out_reg;
    assign corrected_error_flag_n_o = sbc_out_reg;
    assign test_data_o = tdo_reg;
    assign outputs_oe_n_o = oe_n_reg;
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i || !ce_i);

    a_addr_copies: assert property (mem_address_copy_a_o == mem_address_copy_b_o &&
        $past(seq_addr) == mem_address_copy_a_o) else $error("address copies differ");
    a_strobe_copies: assert property (row_strobe_copy_a_n_o == row_strobe_copy_b_n_o &&
        column_strobe_copy_a_n_o == column_strobe_copy_b_n_o) else $error("strobe copies differ");
    a_we_follows: assert property (!write_enable_copy_0_n_o |->
        !write_enable_copy_1_n_o && !interface_chip_write_drive_n_o[0] && (column_strobe_copy_a_n_o != '1))
        else $error("write enable outside a write column phase");
    a_reset_memory_side_reset_out: assert property ($fell(rst_i) |-> !memory_side_reset_out_n_o[*8])
        else $error("memory reset not held after hard reset");
    a_sbc_report: assert property (sbc_event && (merr_en_reg || serr_en_reg) |=> ##1
        !corrected_error_flag_n_o) else $error("corrected error not flagged");
    a_sbc_quiet: assert property (!merr_en_reg && !serr_en_reg && !sbc_reg |=> ##1
        corrected_error_flag_n_o) else $error("flag without enable");
    a_cnum_sample: assert property ($fell(rst_i) |-> cnum_reg == $past(strap_in))
        else $error("controller number not sampled at reset");
    a_init_den: assert property (init_in && !(hit && wb_we_i) |=> host_data_enable_out_n_o &&
        system_side_command_out_n_o == 5'h1f && $stable(merr_en_reg) && $stable(ctrl_reg))
        else $error("host init did not idle host side");
    a_tdo_quiet: assert property (!tms_in |=> !test_data_o) else $error("test output moved");
    a_float_test: assert property (board_test |=> outputs_oe_n_o && memory_side_command_bus_oe_n_o)
        else $error("outputs driven in board test");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
endmodule

// [include/dram_ctrl_defs.svh]
`ifndef DRAM_CTRL_DEFS_SVH
`define DRAM_CTRL_DEFS_SVH

// Register byte offsets
`define OFF_CTRL 8'h00
`define OFF_ACCESS 8'h04
`define OFF_STATUS 8'h08
`define OFF_MERR_CMD 8'h0c
`define OFF_SERR_CMD 8'h10
`define OFF_CMD 8'h14
`define OFF_CNUM 8'h18

// Control register fields
`define CTRL_MEM_RESET 0
`define CTRL_DATA_EN 1
`define CTRL_RESET_VAL 2'h0

// Access register fields
`define ACC_ROW_LSB 0
`define ACC_COL_LSB 13
`define ACC_SEL_LSB 26
`define ACC_WR_BIT 29

// Status register fields
`define STAT_BUSY 0
`define STAT_SBC 1
`define STAT_SERR 2
`define STAT_MERR_LSB 3
`define STAT_CNUM 5
`define STAT_MCMD_LSB 8

// Error command registers: corrected-error report enable
`define ERRCMD_SBC_EN 0

// Command register fields
`define CMD_SYS_LSB 0
`define CMD_MIC_LSB 5
`define CMD_MEM_LSB 12
`define CMD_MEM_DRIVE 20

// Memory error code for a corrected single-bit error
`define MEMORY_ERROR_IN_SBC 2'h1

// Timing
`define CLK_MHZ 200
`define CLK_PERIOD_PS (1000000 / `CLK_MHZ)
`define T_RCD_NS 15
`define T_CAS_NS 15
`define T_RP_NS 40
`define T_MEMORY_SIDE_RESET_OUT_NS 100
`define CYC_MIN(ns) (((ns) * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define RCD_CYC `CYC_MIN(`T_RCD_NS)
`define CAS_CYC `CYC_MIN(`T_CAS_NS)
`define RP_CYC `CYC_MIN(`T_RP_NS)
`define MEMORY_SIDE_RESET_OUT_CYC `CYC_MIN(`T_MEMORY_SIDE_RESET_OUT_NS)

`endif

// [include/dram_pkg.sv]
package dram_pkg;
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_ROW, SEQ_COL, SEQ_PRE} seq_state_e;
    typedef logic [12:0] mem_addr_t;
    typedef logic [7:0] count_t;
endpackage

// [logic/dram_strobe_seq.sv]
`timescale 1ns/1ps
`include "dram_ctrl_defs.svh"

module dram_strobe_seq
    import dram_pkg::*;
#(
    parameter int NUM_ROWS = 8,
    parameter int SEL_W = 3
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic start_i,
    input wire mem_addr_t row_addr_i,
    input wire mem_addr_t col_addr_i,
    input wire logic [SEL_W-1:0] row_sel_i,
    input wire logic write_i,
    output logic busy_o,
    output mem_addr_t addr_o,
    output logic [NUM_ROWS-1:0] row_strobe_o,
    output logic [NUM_ROWS-1:0] col_strobe_o,
    output logic write_o,
    output logic drive_o
);
    seq_state_e state_reg, state_next;
    count_t cnt_reg, cnt_next;
    mem_addr_t addr_reg, addr_next, col_reg, col_next;
    logic [SEL_W-1:0] sel_reg, sel_next;
    logic [NUM_ROWS-1:0] ras_reg, ras_next, cas_reg, cas_next;
    logic wr_reg, wr_next, we_reg, we_next, drv_reg, drv_next;

    function automatic logic [NUM_ROWS-1:0] row_onehot(input logic [SEL_W-1:0] sel);
        logic [NUM_ROWS-1:0] v;
        v = '0;
        v[sel] = 1'b1;
        return v;
    endfunction

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        addr_next = addr_reg;
        col_next = col_reg;
        sel_next = sel_reg;
        ras_next = ras_reg;
        cas_next = cas_reg;
        wr_next = wr_reg;
        we_next = we_reg;
        drv_next = drv_reg;
        case (state_reg)
            SEQ_IDLE: begin
                if (start_i) begin
                    addr_next = row_addr_i;
                    col_next = col_addr_i;
                    sel_next = row_sel_i;
                    wr_next = write_i;
                    ras_next = row_onehot(row_sel_i);
                    cnt_next = count_t'(`RCD_CYC - 1);
                    state_next = SEQ_ROW;
                end
            end
            SEQ_ROW: begin
                if (cnt_reg == '0) begin
                    addr_next = col_reg;
                    cas_next = row_onehot(sel_reg);
                    we_next = wr_reg;
                    drv_next = wr_reg;
                    cnt_next = count_t'(`CAS_CYC - 1);
                    state_next = SEQ_COL;
                end else begin
                    cnt_next = cnt_reg - 8'h01;
                end
            end
            SEQ_COL: begin
                if (cnt_reg == '0) begin
                    // Row strobe held until column strobe ends
                    ras_next = '0;
                    cas_next = '0;
                    we_next = 1'b0;
                    drv_next = 1'b0;
                    cnt_next = count_t'(`RP_CYC - 1);
                    state_next = SEQ_PRE;
                end else begin
                    cnt_next = cnt_reg - 8'h01;
                end
            end
            SEQ_PRE: begin
                if (cnt_reg == '0) begin
                    state_next = SEQ_IDLE;
                end else begin
                    cnt_next = cnt_reg - 8'h01;
                end
            end
            default: state_next = SEQ_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_reg <= SEQ_IDLE;
            cnt_reg <= '0;
            addr_reg <= '0;
            col_reg <= '0;
            sel_reg <= '0;
            ras_reg <= '0;
            cas_reg <= '0;
            wr_reg <= 1'b0;
            we_reg <= 1'b0;
            drv_reg <= 1'b0;
        end else if (ce_i) begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            addr_reg <= addr_next;
            col_reg <= col_next;
            sel_reg <= sel_next;
            ras_reg <= ras_next;
            cas_reg <= cas_next;
            wr_reg <= wr_next;
            we_reg <= we_next;
            drv_reg <= drv_next;
        end
    end

    assign busy_o = (state_reg != SEQ_IDLE);
    assign addr_o = addr_reg;
    assign row_strobe_o = ras_reg;
    assign col_strobe_o = cas_reg;
    assign write_o = we_reg;
    assign drive_o = drv_reg;

    // Column phase: column address out, every column strobe under its row strobe
    sequence s_col_hold;
        ((|cas_reg) && (addr_reg == col_reg) && ((cas_reg & ~ras_reg) == '0))[*3];
    endsequence

    sequence s_both_off;
        !(|cas_reg) && !(|ras_reg);
    endsequence

    a_ras_before_cas: assert property (@(posedge sys_clk_i) disable iff (rst_i || !ce_i)
        $rose(|cas_reg) |-> $past((|ras_reg) && !(|cas_reg)) && ((cas_reg & ~ras_reg) == '0))
        else $error("column strobe without its row strobe");
    a_cas_width: assert property (@(posedge sys_clk_i) disable iff (rst_i || !ce_i)
        $rose(|cas_reg) |-> s_col_hold ##1 s_both_off)
        else $error("column strobe width or address wrong");
endmodule

// [bench/far_side.sv]
`timescale 1ns/1ps
module far_side (
    input wire logic [7:0] ctrl_bus_i,
    input wire logic ctrl_oe_n_i,
    input wire logic [7:0] own_bus_i,
    output logic [7:0] bus_o
);
    // Data-path chip drives the shared bus whenever the controller lets go
    assign bus_o = ctrl_oe_n_i ? own_bus_i : ctrl_bus_i;
endmodule

// [bench/tb.sv]
`timescale 1ns/1ps
module tb;
    import dram_pkg::*;
    logic sys_clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, ini = 1'b1, se = 1'b1;
    logic pg = 1'b1, rg = 1'b1, tck = 1'b0, tms = 1'b0, we0, we1, boe, den, mr, fl, tdo, oen;
    logic [7:0] adr = 8'h00, ca, cb, ra, rb, bo, bw, s;
    logic [31:0] dat = 32'h0, rdat, rd;
    logic [1:0] me = 2'h3, mwc;
    logic [4:0] sc;
    logic [6:0] mc;
    mem_addr_t ma, mb;
    int err_total = 0, n_compared = 0;
    always #2.5 sys_clk_i = ~sys_clk_i;
    far_side i_far (.ctrl_bus_i(bo), .ctrl_oe_n_i(boe), .own_bus_i(8'hc3), .bus_o(bw));
    dram_control_signalling i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .column_strobe_copy_a_n_o(ca), .column_strobe_copy_b_n_o(cb),
        .row_strobe_copy_a_n_o(ra), .row_strobe_copy_b_n_o(rb), .mem_address_copy_a_o(ma),
        .mem_address_copy_b_o(mb), .write_enable_copy_0_n_o(we0), .write_enable_copy_1_n_o(we1),
        .memory_side_command_bus_n_i(bw), .memory_side_command_bus_n_o(bo), .memory_side_command_bus_oe_n_o(boe),
        .memory_error_in_n_i(me), .system_side_command_out_n_o(sc), .host_data_enable_out_n_o(den),
        .system_error_in_n_i(se), .interface_chip_command_n_o(mc), .interface_chip_write_drive_n_o(mwc),
        .host_bus_init_n_i(ini), .memory_side_reset_out_n_o(mr), .corrected_error_flag_n_o(fl),
        .controller_number_strap_i(1'b1), .power_good_i(pg), .receiver_gate_test_i(rg), .test_clk_i(tck),
        .test_data_i(tck), .test_mode_sel_i(tms), .test_reset_n_i(1'b1), .test_data_o(tdo), .outputs_oe_n_o(oen));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge sys_clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge sys_clk_i);
            n++;
            if (n > 20) begin
                chk("ack", 1'h1, 1'h0);
                wrap_up();
            end
        end while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // Poll a strobe group at the falling edge until it leaves all-negated
    task automatic wait_lo(input bit col);
        for (int n = 0; (col ? ca : ra) === 8'hff; n++) begin
            @(negedge sys_clk_i);
            if (n > 30) begin
                chk("strobe", 1'h1, 1'h0);
                wrap_up();
            end
        end
    endtask
    initial begin
        repeat (8) @(posedge sys_clk_i);
        chk("mrst held", 1'h0, mr);
        rst_i <= 1'b0;
        repeat (30) @(negedge sys_clk_i);
        chk("mrst off", 1'h1, mr);
        wb(1'b0, 8'h18, 32'h0);
        chk("cnum", 1'h1, rd);
        wb(1'b1, 8'h14, 32'h001a566c);
        repeat (3) @(negedge sys_clk_i);
        chk("sys cmd", 5'h13, sc);
        chk("mic cmd", 7'h4c, mc);
        chk("mem cmd", 8'h5a, bw);
        wb(1'b1, 8'h14, 32'h000a566c);
        repeat (4) @(negedge sys_clk_i);
        wb(1'b0, 8'h08, 32'h0);
        chk("status", 16'h3c20, rd);
        $display("test commands ended");
        for (int k = 0; k < 2; k++) begin
            s = k ? 8'hfe : 8'h7f;
            wb(1'b1, 8'h04, {2'h0, k ? 4'h0 : 4'hf, 13'h0123, 13'h1abc});
            wait_lo(1'b0);
            chk("row", {s, 8'hff, 3'h0, 13'h1abc}, {ra, ca, 3'h0, ma});
            wait_lo(1'b1);
            chk("col", {s, s, 3'h0, 13'h0123}, {ra, ca, 3'h0, ma});
            chk("write", k ? 3'h7 : 3'h0, {mwc, we0});
            chk("copies", {ra, ca, ma, we0}, {rb, cb, mb, we1});
            repeat (20) @(negedge sys_clk_i);
        end
        $display("test access ended");
        wb(1'b1, 8'h00, 32'h3);
        repeat (3) @(negedge sys_clk_i);
        chk("den mrst", 2'h0, {den, mr});
        @(posedge sys_clk_i) ini <= 1'b0;
        repeat (4) @(negedge sys_clk_i);
        chk("den init", {1'h1, 5'h1f}, {den, sc});
        @(posedge sys_clk_i) ini <= 1'b1;
        wb(1'b0, 8'h00, 32'h0);
        chk("ctrl kept", 2'h3, rd);
        wb(1'b1, 8'h0c, 32'h1);
        @(posedge sys_clk_i) me <= 2'h2;
        se <= 1'b0;
        repeat (6) @(negedge sys_clk_i);
        chk("flag", 1'h0, fl);
        @(posedge sys_clk_i) me <= 2'h3;
        se <= 1'b1;
        wb(1'b0, 8'h08, 32'h0);
        chk("status err", 16'h3c2e, rd);
        wb(1'b1, 8'h08, 32'h6);
        repeat (3) @(negedge sys_clk_i);
        chk("flag clr", 1'h1, fl);
        repeat (4) @(posedge sys_clk_i) tck <= ~tck;
        repeat (3) @(negedge sys_clk_i);
        chk("tdo", 1'h0, tdo);
        @(posedge sys_clk_i) tms <= 1'b1;
        repeat (2) @(posedge sys_clk_i) tck <= ~tck;
        repeat (4) @(negedge sys_clk_i);
        chk("tdo on", 1'h1, tdo);
        @(posedge sys_clk_i) pg <= 1'b0;
        rg <= 1'b0;
        repeat (4) @(negedge sys_clk_i);
        chk("float", 1'h1, oen);
        $display("test misc ended");
        wrap_up();
    end
endmodule
